// file: vsr_regs.sv
`timescale 1ns/1ps
`include "vsr_cfg.svh"

module vsr_regs
  import vsr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Host I/O port
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic irq_o,
  // Video timing
  input wire logic line_done_i,
  input wire logic frame_start_i,
  input wire logic vblank_i,
  // Beam position and lookups
  input wire logic [7:0] pix_x_i,
  input wire logic [7:0] line_y_i,
  input wire logic [7:0] spr_idx_i,
  // Display control
  output vsr_disp_s disp_o,
  output logic [7:0] vscroll_o,
  output logic [7:0] src_x_o,
  output logic [4:0] map_row_o,
  output logic [2:0] fine_row_o,
  output logic [13:0] spr_addr_o,
  output logic spr_ok_o,
  output logic [4:0] border_o,
  output logic raster_hit_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Power-on value of one register
  function automatic logic [7:0] rst_val(input logic [3:0] idx);
    logic [7:0] v;
    case (idx)
      `VSR_IDX_MODE0: v = `VSR_RST_MODE0;
      `VSR_IDX_MODE1: v = `VSR_RST_MODE1;
      `VSR_IDX_SPR: v = `VSR_RST_SPR;
      `VSR_IDX_BORDER: v = `VSR_RST_ZERO;
      `VSR_IDX_HSCROLL: v = `VSR_RST_ZERO;
      `VSR_IDX_VSCROLL: v = `VSR_RST_ZERO;
      `VSR_IDX_RASTER: v = `VSR_RST_RASTER;
      default: v = `VSR_RST_FF;
    endcase
    return v;
  endfunction

  // Value actually stored for a write
  function automatic logic [7:0] store_val(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (idx == `VSR_IDX_SPR)
    begin
      v = d[`VSR_SPR_UPPER_BIT] ? `VSR_SPR_HI : `VSR_SPR_LO;
    end
    else if (idx == `VSR_IDX_BORDER)
    begin
      v = {`VSR_BORDER_ONES, d[3:0]};
    end
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------

  vsr_top_s st_r;
  vsr_top_s st_nxt;
  vsr_top_s st_rst;
  logic raster_hit;
  logic ctrl_wr;
  logic ctrl_rd;
  logic data_acc;
  logic line_ie;
  logic frame_ie;
  logic [3:0] wr_idx;

  assign ctrl_wr = io_wr_i && (io_addr_i == `VSR_PORT_CTRL);
  assign ctrl_rd = io_rd_i && (io_addr_i == `VSR_PORT_CTRL);
  assign data_acc = (io_wr_i || io_rd_i) && (io_addr_i == `VSR_PORT_DATA);
  assign wr_idx = io_wdata_i[3:0];
  assign line_ie = st_r.regs[`VSR_IDX_MODE0][`VSR_LINE_IE_BIT];
  assign frame_ie = st_r.regs[`VSR_IDX_MODE1][`VSR_FRAME_IE_BIT];

  // Reset image of the whole state
  always_comb
  begin
    st_rst = '0;
    for (int i = 0; i < 11; i++)
    begin
      st_rst.regs[i] = rst_val(4'(i));
    end
    st_rst.wr_st = VSR_WAIT_VALUE;
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // Port writes, status reads and pending flags
  always_comb
  begin
    st_nxt = st_r;
    if (ctrl_wr)
    begin
      case (st_r.wr_st)
        VSR_WAIT_VALUE:
        begin
          st_nxt.latch = io_wdata_i;
          st_nxt.wr_st = VSR_WAIT_CMD;
        end
        VSR_WAIT_CMD:
        begin
          st_nxt.wr_st = VSR_WAIT_VALUE;
          if (io_wdata_i[7:4] == `VSR_CMD_NIBBLE && wr_idx < `VSR_REG_CNT)
          begin
            st_nxt.regs[wr_idx] = store_val(wr_idx, st_r.latch);
          end
        end
        default:
        begin
          st_nxt.wr_st = VSR_WAIT_VALUE;
        end
      endcase
    end
    if (ctrl_rd || data_acc)
    begin
      st_nxt.wr_st = VSR_WAIT_VALUE;
    end
    if (ctrl_rd)
    begin
      st_nxt.rdata = 8'h00;
      st_nxt.rdata[`VSR_STAT_FRAME_BIT] = st_r.frame_pend;
      st_nxt.rdata[`VSR_STAT_LINE_BIT] = st_r.line_pend;
      st_nxt.frame_pend = 1'b0;
      st_nxt.line_pend = 1'b0;
    end
    // A new event wins over a clear in the same cycle
    if (frame_start_i)
    begin
      st_nxt.frame_pend = 1'b1;
    end
    if (raster_hit)
    begin
      st_nxt.line_pend = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      st_r <= st_rst;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------------

  // Raster-line request counter
  vsr_raster u_raster (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .line_done_i(line_done_i),
    .frame_start_i(frame_start_i),
    .compare_i(st_r.regs[`VSR_IDX_RASTER]),
    .hit_o(raster_hit)
  );

  // Scroll, sprite and border lookups
  vsr_view u_view (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .vscroll_reg_i(st_r.regs[`VSR_IDX_VSCROLL]),
    .hscroll_i(st_r.regs[`VSR_IDX_HSCROLL]),
    .spr_base_i(st_r.regs[`VSR_IDX_SPR]),
    .border_i(st_r.regs[`VSR_IDX_BORDER]),
    .vblank_i(vblank_i),
    .pix_x_i(pix_x_i),
    .line_y_i(line_y_i),
    .spr_idx_i(spr_idx_i),
    .vscroll_o(vscroll_o),
    .src_x_o(src_x_o),
    .map_row_o(map_row_o),
    .fine_row_o(fine_row_o),
    .spr_addr_o(spr_addr_o),
    .spr_ok_o(spr_ok_o),
    .border_o(border_o)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // Request gated by the matching enables
  assign irq_o = (st_r.line_pend && line_ie) || (st_r.frame_pend && frame_ie);
  assign io_rdata_o = st_r.rdata;
  assign raster_hit_o = raster_hit;
  assign disp_o.mode0 = st_r.regs[`VSR_IDX_MODE0];
  assign disp_o.mode1 = st_r.regs[`VSR_IDX_MODE1];
  assign disp_o.map_base = st_r.regs[`VSR_IDX_MAP];
  assign disp_o.sat_base = st_r.regs[`VSR_IDX_SAT];
  assign disp_o.hscroll = st_r.regs[`VSR_IDX_HSCROLL];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------

  // Sprite base only ever holds one of two settings
  spr_base_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    st_r.regs[`VSR_IDX_SPR] == `VSR_SPR_LO || st_r.regs[`VSR_IDX_SPR] == `VSR_SPR_HI)
    else $error("sprite base out of range");

  // Border register upper nibble stays ones after a write
  border_ones_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ctrl_wr && st_r.wr_st == VSR_WAIT_CMD && io_wdata_i == 8'h87)
      |=> st_r.regs[`VSR_IDX_BORDER] == {4'hf, $past(st_r.latch[3:0])})
    else $error("border write stored wrongly");

  // Reset release leaves the power-on values
  por_a: assert property (@(posedge sys_clk_i)
    $fell(rst_i) |-> st_r.regs[0] == 8'h36 && st_r.regs[1] == 8'ha0
      && st_r.regs[6] == 8'hfb && st_r.regs[10] == 8'hff && st_r.regs[9] == 8'h00)
    else $error("power-on values wrong");

  // Status read without a new event clears both pending flags
  rd_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ctrl_rd && !frame_start_i && !raster_hit) |=> !st_r.frame_pend && !st_r.line_pend)
    else $error("status read did not clear");

  // Status read returns the pending flags
  rd_data_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ctrl_rd |=> io_rdata_o[7] == $past(st_r.frame_pend) && io_rdata_o[6] == $past(st_r.line_pend))
    else $error("status data wrong");

  // Raster request raises the output when line enable is set
  line_irq_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (raster_hit && line_ie && !(ctrl_wr && st_r.wr_st == VSR_WAIT_CMD)) |=> irq_o)
    else $error("line request not raised");

  // Request holds until a status read or a control-port write
  irq_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (irq_o && !ctrl_rd && !ctrl_wr) |=> irq_o)
    else $error("request dropped without read");

  // Disabled line request never drives the output alone
  irq_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!line_ie && !st_r.frame_pend) |-> !irq_o)
    else $error("request while disabled");

  // Frame event raises the output when frame enable is set
  frame_irq_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (frame_start_i && frame_ie && !(ctrl_wr && st_r.wr_st == VSR_WAIT_CMD)) |=> irq_o)
    else $error("frame request not raised");

  // Raster event always leaves the line flag pending
  line_pend_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    raster_hit |=> st_r.line_pend)
    else $error("line flag not set");

  // Frame event always leaves the frame flag pending
  frame_pend_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    frame_start_i |=> st_r.frame_pend)
    else $error("frame flag not set");

  // Status read without a new event drops the request
  irq_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ctrl_rd && !frame_start_i && !raster_hit) |=> !irq_o)
    else $error("request kept after read");

  // Sprite base write keeps only the half select
  spr_store_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ctrl_wr && st_r.wr_st == VSR_WAIT_CMD && io_wdata_i == 8'h86)
      |=> st_r.regs[`VSR_IDX_SPR] == ($past(st_r.latch[`VSR_SPR_UPPER_BIT]) ? `VSR_SPR_HI : `VSR_SPR_LO))
    else $error("sprite base stored wrongly");

endmodule // vsr_regs

// file: vsr_cfg.svh
`ifndef VSR_CFG_SVH
`define VSR_CFG_SVH

// ----------------------------------------------------------------------
// Host I/O port decode
// ----------------------------------------------------------------------
`define VSR_PORT_DATA 8'hbe
`define VSR_PORT_CTRL 8'hbf
`define VSR_CMD_NIBBLE 4'h8
`define VSR_REG_CNT 4'hb

// ----------------------------------------------------------------------
// Register indices and power-on values
// ----------------------------------------------------------------------
`define VSR_IDX_MODE0 4'h0
`define VSR_IDX_MODE1 4'h1
`define VSR_IDX_MAP 4'h2
`define VSR_IDX_SAT 4'h5
`define VSR_IDX_SPR 4'h6
`define VSR_IDX_BORDER 4'h7
`define VSR_IDX_HSCROLL 4'h8
`define VSR_IDX_VSCROLL 4'h9
`define VSR_IDX_RASTER 4'ha
`define VSR_RST_MODE0 8'h36
`define VSR_RST_MODE1 8'ha0
`define VSR_RST_FF 8'hff
`define VSR_RST_SPR 8'hfb
`define VSR_RST_ZERO 8'h00
`define VSR_RST_RASTER 8'hff

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define VSR_LINE_IE_BIT 4
`define VSR_FRAME_IE_BIT 5
`define VSR_STAT_FRAME_BIT 7
`define VSR_STAT_LINE_BIT 6
`define VSR_SPR_UPPER_BIT 2
`define VSR_SPR_LO 8'hfb
`define VSR_SPR_HI 8'hff
`define VSR_BORDER_ONES 4'hf

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define VSR_SPR_UPPER_MAX 8'd192
`define VSR_SPR_UPPER_BASE 14'h2000
`define VSR_VWRAP 9'd224
`define VSR_BORDER_BANK 1'b1

`endif

// file: vsr_pkg.sv
package vsr_pkg;

  // Pairing state of the control port
  typedef enum logic [0:0] {
    VSR_WAIT_VALUE = 1'b0,
    VSR_WAIT_CMD = 1'b1
  } vsr_wr_e;

  // Top-level state
  typedef struct packed {
    logic [10:0][7:0] regs;
    logic [7:0] latch;
    vsr_wr_e wr_st;
    logic frame_pend;
    logic line_pend;
    logic [7:0] rdata;
  } vsr_top_s;

  // Raster counter state
  typedef struct packed {
    logic [7:0] cnt;
    logic hit;
  } vsr_rast_s;

  // Display-side lookups
  typedef struct packed {
    logic [7:0] vscroll;
    logic [7:0] src_x;
    logic [4:0] map_row;
    logic [2:0] fine_row;
    logic [13:0] spr_addr;
    logic spr_ok;
    logic [4:0] border;
  } vsr_view_s;

  // Control fields passed to the display logic
  typedef struct packed {
    logic [7:0] mode0;
    logic [7:0] mode1;
    logic [7:0] map_base;
    logic [7:0] sat_base;
    logic [7:0] hscroll;
  } vsr_disp_s;

endpackage

// file: vsr_raster.sv
`timescale 1ns/1ps
`include "vsr_cfg.svh"

module vsr_raster
  import vsr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Timing events
  input wire logic line_done_i,
  input wire logic frame_start_i,
  // Compare value
  input wire logic [7:0] compare_i,
  // Request pulse
  output logic hit_o
);

  vsr_rast_s st_r;
  vsr_rast_s st_nxt;

  // Countdown, reloaded on expiry and at frame start
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.hit = 1'b0;
    if (frame_start_i)
    begin
      st_nxt.cnt = compare_i;
    end
    else if (line_done_i)
    begin
      if (st_r.cnt == 8'h00)
      begin
        st_nxt.hit = 1'b1;
        st_nxt.cnt = compare_i;
      end
      else
      begin
        st_nxt.cnt = st_r.cnt - 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      st_r <= '{cnt: `VSR_RST_RASTER, hit: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign hit_o = st_r.hit;

  // A request follows only an expiring line end
  hit_cause_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    hit_o |-> $past(line_done_i) && $past(st_r.cnt) == 8'h00 && !$past(frame_start_i))
    else $error("raster request without expiry");

  // Expiry reloads the working count from the compare value
  reload_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (line_done_i && !frame_start_i && st_r.cnt == 8'h00) |=> st_r.cnt == $past(compare_i))
    else $error("counter not reloaded on expiry");

  // Compare zero requests on every counted line
  every_line_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (line_done_i && !frame_start_i && st_r.cnt == 8'h00 && compare_i == 8'h00)
      ##1 (!line_done_i && !frame_start_i) ##1 (line_done_i && !frame_start_i) |=> hit_o)
    else $error("zero compare missed a line");

endmodule // vsr_raster

// file: vsr_view.sv
`timescale 1ns/1ps
`include "vsr_cfg.svh"

module vsr_view
  import vsr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register values
  input wire logic [7:0] vscroll_reg_i,
  input wire logic [7:0] hscroll_i,
  input wire logic [7:0] spr_base_i,
  input wire logic [7:0] border_i,
  // Frame timing and beam position
  input wire logic vblank_i,
  input wire logic [7:0] pix_x_i,
  input wire logic [7:0] line_y_i,
  input wire logic [7:0] spr_idx_i,
  // Lookup results
  output logic [7:0] vscroll_o,
  output logic [7:0] src_x_o,
  output logic [4:0] map_row_o,
  output logic [2:0] fine_row_o,
  output logic [13:0] spr_addr_o,
  output logic spr_ok_o,
  output logic [4:0] border_o
);

  vsr_view_s st_r;
  vsr_view_s st_nxt;
  logic [8:0] vsum;

  // Lookups for the background, sprites and border
  always_comb
  begin
    st_nxt = st_r;
    if (vblank_i)
    begin
      st_nxt.vscroll = vscroll_reg_i;
    end
    st_nxt.src_x = pix_x_i + hscroll_i;
    vsum = {1'b0, line_y_i} + {1'b0, st_r.vscroll};
    if (vsum >= `VSR_VWRAP)
    begin
      vsum = vsum - `VSR_VWRAP;
    end
    st_nxt.map_row = vsum[7:3];
    st_nxt.fine_row = vsum[2:0];
    if (spr_base_i[`VSR_SPR_UPPER_BIT])
    begin
      st_nxt.spr_addr = `VSR_SPR_UPPER_BASE + {1'b0, spr_idx_i, 5'h00};
      st_nxt.spr_ok = spr_idx_i < `VSR_SPR_UPPER_MAX;
    end
    else
    begin
      st_nxt.spr_addr = {1'b0, spr_idx_i, 5'h00};
      st_nxt.spr_ok = 1'b1;
    end
    st_nxt.border = {`VSR_BORDER_BANK, border_i[3:0]};
  end

  // State register
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign vscroll_o = st_r.vscroll;
  assign src_x_o = st_r.src_x;
  assign map_row_o = st_r.map_row;
  assign fine_row_o = st_r.fine_row;
  assign spr_addr_o = st_r.spr_addr;
  assign spr_ok_o = st_r.spr_ok;
  assign border_o = st_r.border;

  // Working vertical scroll holds outside blanking
  vscroll_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !vblank_i |=> $stable(vscroll_o))
    else $error("vertical scroll changed mid-frame");

  // Map row never reaches the row 28 wrap point
  map_wrap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    map_row_o < 5'd28)
    else $error("map row past wrap");

  // Horizontal source wraps modulo 256
  hwrap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    1'b1 |=> src_x_o == 8'($past(pix_x_i) + $past(hscroll_i)))
    else $error("horizontal source wrong");

  // Upper half refuses patterns 192 and above
  spr_limit_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (spr_base_i[`VSR_SPR_UPPER_BIT] && spr_idx_i >= 8'd192) |=> !spr_ok_o)
    else $error("upper pattern past limit");

endmodule // vsr_view

// file: vsr_host_model.sv
`timescale 1ns/1ps
`include "vsr_cfg.svh"

module vsr_host_model
(
  // Clock
  input wire logic sys_clk_i,
  // I/O port towards the device
  output logic [7:0] io_addr_o,
  output logic io_wr_o,
  output logic io_rd_o,
  output logic [7:0] io_wdata_o,
  input wire logic [7:0] io_rdata_i
);
  // Idle bus at time zero
  initial
  begin
    io_addr_o = 8'h00;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_wdata_o = 8'h00;
  end

  // Two-byte pair on the control port, value first, back to back
  task automatic wr_pair(input logic [7:0] val, input logic [7:0] cmd);
    @(negedge sys_clk_i);
    io_addr_o = `VSR_PORT_CTRL;
    io_wdata_o = val;
    io_wr_o = 1'b1;
    @(negedge sys_clk_i);
    io_wdata_o = cmd;
    @(negedge sys_clk_i);
    io_wr_o = 1'b0;
    io_wdata_o = ~cmd; // Released data no longer shows the last byte
  endtask

  // Register write; sprite base only ever gets fb or ff from here
  task automatic wr_reg(input logic [3:0] idx, input logic [7:0] val);
    wr_pair(val, {`VSR_CMD_NIBBLE, idx});
  endtask

  // Status read, which also clears pending requests
  task automatic rd_stat(output logic [7:0] stat);
    @(negedge sys_clk_i);
    io_addr_o = `VSR_PORT_CTRL;
    io_rd_o = 1'b1;
    @(negedge sys_clk_i);
    io_rd_o = 1'b0;
    stat = io_rdata_i;
  endtask
endmodule // vsr_host_model

// file: video_scroll_raster_irq_regs_tb.sv
`timescale 1ns/1ps
`include "vsr_cfg.svh"

`define CHK(nm, ex, got) \
  begin \
    checks++; \
    if ((got) !== (ex)) \
    begin \
      err_count++; \
      $display("mismatch %s expected %0h seen %0h", nm, ex, got); \
    end \
  end

module video_scroll_raster_irq_regs_tb
  import vsr_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] io_addr, io_wdata, io_rdata, pix_x, line_y, spr_idx, vscroll, src_x;
  logic io_wr, io_rd, irq, line_done, frame_start, vblank, spr_ok, hit;
  logic [4:0] map_row, border;
  logic [2:0] fine_row;
  logic [13:0] spr_addr;
  vsr_disp_s disp;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;

  vsr_host_model u_host (.sys_clk_i(sys_clk_i), .io_addr_o(io_addr), .io_wr_o(io_wr),
    .io_rd_o(io_rd), .io_wdata_o(io_wdata), .io_rdata_i(io_rdata));

  vsr_regs u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .io_addr_i(io_addr), .io_wr_i(io_wr),
    .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .irq_o(irq),
    .line_done_i(line_done), .frame_start_i(frame_start), .vblank_i(vblank),
    .pix_x_i(pix_x), .line_y_i(line_y), .spr_idx_i(spr_idx), .disp_o(disp),
    .vscroll_o(vscroll), .src_x_o(src_x), .map_row_o(map_row), .fine_row_o(fine_row),
    .spr_addr_o(spr_addr), .spr_ok_o(spr_ok), .border_o(border), .raster_hit_o(hit));

  // 25 MHz clock
  initial
  begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // Counts and verdict, then end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end

  // One frame: blanking, then 192 active lines; optional compare rewrite after first hit
  task automatic run_frame(input bit late, output int hits, output int first,
    output int second);
    hits = 0;
    first = -1;
    second = -1;
    @(negedge sys_clk_i);
    frame_start = 1'b1;
    vblank = 1'b1;
    @(negedge sys_clk_i);
    frame_start = 1'b0;
    @(negedge sys_clk_i);
    vblank = 1'b0;
    for (int ln = 0; ln < 192; ln++)
    begin
      @(negedge sys_clk_i);
      line_done = 1'b1;
      @(negedge sys_clk_i);
      line_done = 1'b0;
      if (hit === 1'b1)
      begin
        if (hits == 0)
          first = ln;
        else if (hits == 1)
          second = ln;
        hits++;
        if (late && hits == 1)
          u_host.wr_reg(`VSR_IDX_RASTER, 8'd150);
      end
    end
    // Let a request on the last line reach the pending flag
    @(negedge sys_clk_i);
  endtask

  // Main sequence
  initial
  begin
    logic [7:0] st;
    int h, f, s;
    logic [7:0] cmp [5] = '{8'h00, 8'h01, 8'd94, 8'hbf, 8'hc0};
    int exh [5] = '{192, 96, 2, 1, 0};
    int exf [5] = '{0, 1, 94, 191, -1};
    {line_done, frame_start, vblank} = 3'b000;
    {pix_x, line_y, spr_idx} = 24'h000000;
    repeat (8) @(negedge sys_clk_i);
    rst_i = 1'b0;
    @(negedge sys_clk_i);
    `CHK("mode0", 8'h36, disp.mode0)
    `CHK("mode1", 8'ha0, disp.mode1)
    `CHK("map_base", 8'hff, disp.map_base)
    `CHK("sat_base", 8'hff, disp.sat_base)
    `CHK("hscroll", 8'h00, disp.hscroll)
    `CHK("vscroll", 8'h00, vscroll)
    `CHK("irq_rst", 1'b0, irq)
    // Default compare ff gives no line request; frame request is enabled
    run_frame(1'b0, h, f, s);
    `CHK("hits_ff", 0, h)
    `CHK("irq_frame", 1'b1, irq)
    u_host.rd_stat(st);
    `CHK("stat_frame", 8'h80, st)
    `CHK("irq_clr", 1'b0, irq)
    // Sprite pattern base, both halves
    u_host.wr_reg(`VSR_IDX_SPR, `VSR_SPR_HI);
    spr_idx = 8'd191;
    repeat (2) @(negedge sys_clk_i);
    `CHK("spr_ok191", 1'b1, spr_ok)
    `CHK("spr_addr_hi", 14'h37e0, spr_addr)
    spr_idx = 8'd192;
    repeat (2) @(negedge sys_clk_i);
    `CHK("spr_ok192", 1'b0, spr_ok)
    u_host.wr_reg(`VSR_IDX_SPR, `VSR_SPR_LO);
    spr_idx = 8'd255;
    repeat (2) @(negedge sys_clk_i);
    `CHK("spr_ok255", 1'b1, spr_ok)
    `CHK("spr_addr_lo", 14'h1fe0, spr_addr)
    // Border index from the second bank
    u_host.wr_reg(`VSR_IDX_BORDER, 8'hf5);
    repeat (2) @(negedge sys_clk_i);
    `CHK("border", 5'h15, border)
    // Horizontal wrap, then two refused command bytes
    u_host.wr_reg(`VSR_IDX_HSCROLL, 8'hff);
    pix_x = 8'h01;
    repeat (2) @(negedge sys_clk_i);
    `CHK("src_x", 8'h00, src_x)
    u_host.wr_pair(8'h11, 8'h98);
    u_host.wr_pair(8'h22, 8'h8b);
    `CHK("hscroll_keep", 8'hff, disp.hscroll)
    // Vertical scroll waits for blanking, then wraps at row 28
    u_host.wr_reg(`VSR_IDX_VSCROLL, 8'h10);
    repeat (2) @(negedge sys_clk_i);
    `CHK("vscroll_hold", 8'h00, vscroll)
    vblank = 1'b1;
    line_y = 8'hd8;
    repeat (3) @(negedge sys_clk_i);
    vblank = 1'b0;
    `CHK("vscroll_load", 8'h10, vscroll)
    `CHK("map_row", 5'd1, map_row)
    `CHK("fine_row", 3'd0, fine_row)
    // Frame request off so irq shows the line request alone
    u_host.wr_reg(`VSR_IDX_MODE1, 8'h80);
    for (int i = 0; i < 5; i++)
    begin
      u_host.wr_reg(`VSR_IDX_RASTER, cmp[i]);
      run_frame(1'b0, h, f, s);
      `CHK("hits", exh[i], h)
      `CHK("first", exf[i], f)
      `CHK("irq_line", exh[i] > 0, irq)
      u_host.rd_stat(st);
      `CHK("stat", {1'b1, exh[i] > 0, 6'h00}, st)
    end
    // Rewrite mid-frame applies only after the next request
    u_host.wr_reg(`VSR_IDX_RASTER, 8'd20);
    run_frame(1'b1, h, f, s);
    `CHK("late_first", 20, f)
    `CHK("late_second", 41, s)
    `CHK("late_hits", 2, h)
    u_host.rd_stat(st);
    `CHK("late_stat", 8'hc0, st)
    // Line enable off gates the request but not the status
    u_host.wr_reg(`VSR_IDX_MODE0, 8'h26);
    u_host.wr_reg(`VSR_IDX_RASTER, 8'h00);
    run_frame(1'b0, h, f, s);
    `CHK("irq_gated", 1'b0, irq)
    u_host.rd_stat(st);
    `CHK("stat_gated", 8'hc0, st)
    print_verdict();
  end
endmodule // video_scroll_raster_irq_regs_tb
